//--- common/dtc_pkg.sv
/*
 * Shared constants for the dual 16-bit timer/event counter block:
 * register indices, control field positions, reset values, modes.
 * Assumes an 8-bit register port with byte indices as addresses.
 */
package dtc_pkg;

    localparam int DTC_ADDR_W = 6;
    localparam int DTC_DATA_W = 8;
    localparam int DTC_CNT_W = 16;

    // register indices
    localparam logic [5:0] DTC_A_INTC = 6'h0b;
    localparam logic [5:0] DTC_A_T0H = 6'h0c;
    localparam logic [5:0] DTC_A_T0L = 6'h0d;
    localparam logic [5:0] DTC_A_T0C = 6'h0e;
    localparam logic [5:0] DTC_A_T1H = 6'h0f;
    localparam logic [5:0] DTC_A_T1L = 6'h10;
    localparam logic [5:0] DTC_A_T1C = 6'h11;

    // control register fields
    localparam int DTC_C_EDGE = 3;
    localparam int DTC_C_RUN = 4;
    localparam int DTC_C_MLSB = 6;
    localparam int DTC_C_MMSB = 7;
    localparam logic [7:0] DTC_C_RMASK = 8'hd8;
    localparam logic [7:0] DTC_C_RESET = 8'h08;

    // interrupt control fields
    localparam int DTC_I_EN0 = 2;
    localparam int DTC_I_EN1 = 3;
    localparam int DTC_I_F0 = 5;
    localparam int DTC_I_F1 = 6;
    localparam logic [7:0] DTC_I_RMASK = 8'h6c;

    localparam logic [15:0] DTC_CNT_MAX = 16'hffff;
    localparam logic [1:0] DTC_PRESC_LAST = 2'h3;

    typedef enum logic [1:0] {
        DTC_M_UNUSED = 2'h0,
        DTC_M_EVENT = 2'h1,
        DTC_M_TIMER = 2'h2,
        DTC_M_PULSE = 2'h3
    } dtc_mode_t;

endpackage : dtc_pkg

//--- rtl/dtc_counter.sv
/*
 * One 16-bit count-up timer/event counter with preload and control.
 * Assumes pin input synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dtc_counter
    import dtc_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // register access, already decoded
    input wire logic i_wr_low,
    input wire logic i_wr_high,
    input wire logic i_wr_ctrl,
    input wire logic i_rd_cnt,
    input wire logic [7:0] i_wdata,
    input wire logic i_tick,
    // timer pin
    input wire logic i_pin,
    // state out
    output logic [7:0] o_low_buf,
    output logic [15:0] o_count,
    output logic [7:0] o_ctrl,
    output logic o_ovf
);

    logic [7:0] low_buf_ff;
    logic [15:0] count_ff;
    logic [15:0] preload_ff;
    logic [7:0] ctrl_ff;
    logic pin_ff;
    logic pulse_act_ff;

    wire dtc_mode_t mode = dtc_mode_t'(ctrl_ff[DTC_C_MMSB:DTC_C_MLSB]);
    wire logic run = ctrl_ff[DTC_C_RUN];
    wire logic edge_sel = ctrl_ff[DTC_C_EDGE];
    wire logic rise = i_pin & ~pin_ff;
    wire logic fall = ~i_pin & pin_ff;
    // pulse mode: start edge, stop edge
    wire logic p_start = edge_sel ? rise : fall;
    wire logic p_stop = edge_sel ? fall : rise;
    wire logic ev_edge = edge_sel ? fall : rise;
    wire logic pulse_md = (mode == DTC_M_PULSE);
    // step in each mode; clock blocked during reads
    wire logic step = run & ~i_rd_cnt & (
        ((mode == DTC_M_EVENT) & ev_edge) |
        ((mode == DTC_M_TIMER) & i_tick) |
        (pulse_md & pulse_act_ff & i_tick));
    wire logic ovf = step & (count_ff == DTC_CNT_MAX);
    wire logic [15:0] new_pre = {i_wdata, low_buf_ff};
    wire logic pulse_end = pulse_md & run & pulse_act_ff & p_stop;

    logic [15:0] nxt_count;
    logic [7:0] nxt_ctrl;
    logic nxt_pulse_act;

    always_comb begin
        nxt_count = count_ff;
        if (i_wr_high && !run) begin
            nxt_count = new_pre;
        end else if (ovf) begin
            nxt_count = preload_ff;
        end else if (step) begin
            nxt_count = count_ff + 16'h0001;
        end
    end

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (i_wr_ctrl) begin
            nxt_ctrl = i_wdata & DTC_C_RMASK;
        end else if (pulse_end) begin
            nxt_ctrl[DTC_C_RUN] = 1'b0;
        end
    end

    always_comb begin
        nxt_pulse_act = pulse_act_ff;
        if (!pulse_md || !run || pulse_end) begin
            nxt_pulse_act = 1'b0;
        end else if (p_start) begin
            nxt_pulse_act = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            low_buf_ff <= 8'h00;
            count_ff <= 16'h0000;
            preload_ff <= 16'h0000;
            ctrl_ff <= DTC_C_RESET;
            pin_ff <= 1'b0;
            pulse_act_ff <= 1'b0;
        end else begin
            if (i_wr_low) begin
                low_buf_ff <= i_wdata;
            end
            if (i_wr_high) begin
                preload_ff <= new_pre;
            end
            count_ff <= nxt_count;
            ctrl_ff <= nxt_ctrl;
            pin_ff <= i_pin;
            pulse_act_ff <= nxt_pulse_act;
        end
    end

    assign o_low_buf = low_buf_ff;
    assign o_count = count_ff;
    assign o_ctrl = ctrl_ff;
    assign o_ovf = ovf;

endmodule : dtc_counter
`default_nettype wire

//--- rtl/dtc_top.sv
/*
 * Dual 16-bit timer/event counter with an 8-bit register port,
 * interrupt flags/enables and a wake-up output.
 * Assumes strobes and pins synchronous to I_CORE_CLK; read data one
 * cycle after the read strobe; CPU interrupt logic sits outside.
 */
// What this block does
// - two independent 16-bit up counters
// - timer and pulse modes count at clock/4
// - low byte write only fills buffer
// - low byte read returns buffer
// - bits 7:6 select event, timer, pulse
// - overflow reloads preload, sets flag
// - edge bit picks event counting edge
// - pulse mode start/stop edges from edge bit
// - pulse counting starts on edge, not level
// - pulse end clears run bit
// - one measurement until run set again
// - pulse mode overflow reloads and flags
// - run bit enables; software clears otherwise
// - overflow wakes device from halt
// - enable bit 0 blocks interrupt service
// - stopped counter loads on preload write
// - running counter takes preload at overflow
// - count register reads block that counter's clock
// - control bits 0-2 and 5 read zero
`timescale 1ns/1ps
`default_nettype none
module dtc_top
    import dtc_pkg::*;
(
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    // register port
    input wire logic [5:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // timer pins
    input wire logic I_TIMER0_INPUT_PIN,
    input wire logic I_TIMER1_INPUT_PIN,
    // system side
    output logic O_IRQ,
    output logic O_WAKEUP
);

    function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
        hit = (a == r);
    endfunction : hit

    logic [1:0] presc_ff;
    logic [7:0] intc_ff;
    logic [7:0] rdata_ff;
    logic wake_ff;

    // shared fSYS/4 tick
    wire logic tick = (presc_ff == DTC_PRESC_LAST);

    wire logic [5:0] a_high [2] = '{DTC_A_T0H, DTC_A_T1H};
    wire logic [5:0] a_low [2] = '{DTC_A_T0L, DTC_A_T1L};
    wire logic [5:0] a_ctrl [2] = '{DTC_A_T0C, DTC_A_T1C};
    wire logic pins [2] = '{I_TIMER0_INPUT_PIN, I_TIMER1_INPUT_PIN};

    logic [7:0] low_buf [2];
    logic [15:0] count [2];
    logic [7:0] ctrl [2];
    logic [1:0] ovf;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cnt
            wire logic rd_c = I_RD & (hit(I_ADDR, a_high[g]) |
                hit(I_ADDR, a_low[g]));
            dtc_counter u_cnt (
                .i_core_clk(I_CORE_CLK),
                .i_resetn(I_RESETN),
                .i_wr_low(I_WR & hit(I_ADDR, a_low[g])),
                .i_wr_high(I_WR & hit(I_ADDR, a_high[g])),
                .i_wr_ctrl(I_WR & hit(I_ADDR, a_ctrl[g])),
                .i_rd_cnt(rd_c),
                .i_wdata(I_WDATA),
                .i_tick(tick),
                .i_pin(pins[g]),
                .o_low_buf(low_buf[g]),
                .o_count(count[g]),
                .o_ctrl(ctrl[g]),
                .o_ovf(ovf[g])
            );
        end
    endgenerate

    // flags: set wins over software clear
    wire logic wr_intc = I_WR & hit(I_ADDR, DTC_A_INTC);
    logic [7:0] nxt_intc;
    always_comb begin
        nxt_intc = intc_ff;
        if (wr_intc) begin
            nxt_intc = I_WDATA & DTC_I_RMASK;
        end
        nxt_intc[DTC_I_F0] = nxt_intc[DTC_I_F0] | ovf[0];
        nxt_intc[DTC_I_F1] = nxt_intc[DTC_I_F1] | ovf[1];
    end

    // read mux
    logic [7:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 8'h00;
        if (hit(I_ADDR, DTC_A_INTC)) nxt_rdata = intc_ff;
        for (int i = 0; i < 2; i++) begin
            if (hit(I_ADDR, a_high[i])) nxt_rdata = count[i][15:8];
            if (hit(I_ADDR, a_low[i])) nxt_rdata = low_buf[i];
            if (hit(I_ADDR, a_ctrl[i])) nxt_rdata = ctrl[i];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            presc_ff <= 2'h0;
            intc_ff <= 8'h00;
            rdata_ff <= 8'h00;
            wake_ff <= 1'b0;
        end else begin
            presc_ff <= presc_ff + 2'h1;
            intc_ff <= nxt_intc;
            rdata_ff <= I_RD ? nxt_rdata : 8'h00;
            wake_ff <= |ovf;
        end
    end

    assign O_RDATA = rdata_ff;
    assign O_IRQ = (intc_ff[DTC_I_F0] & intc_ff[DTC_I_EN0]) |
        (intc_ff[DTC_I_F1] & intc_ff[DTC_I_EN1]);
    assign O_WAKEUP = wake_ff;

endmodule : dtc_top
`default_nettype wire

//--- sim/dtc_pin_model.sv
/* timer pin model: one high pulse per command.
   assumes commands right after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
    // command
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_len,
    // pin
    output logic o_pin
);
    logic [7:0] cnt_ff = 8'h00;
    always_ff @(posedge i_clk) begin
        if (i_go) begin
            cnt_ff <= i_len;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
    assign o_pin = (cnt_ff != 8'h00);
endmodule : dtc_pin_model
`default_nettype wire

//--- sim/dtc_top_sva.sv
/* port checker for dtc_top.
   assumes bind onto every dtc_top. */
`timescale 1ns/1ps
`default_nettype none
module dtc_top_sva
    import dtc_pkg::*;
(
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    // register port
    input wire logic [5:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    // system side
    input wire logic O_IRQ,
    input wire logic O_WAKEUP
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESETN);
    wire c_rd = I_RD && (I_ADDR == DTC_A_T0C || I_ADDR == DTC_A_T1C);
    wire i_wr = I_WR && I_ADDR == DTC_A_INTC;
    rd_idle_a: assert property (!I_RD |=> O_RDATA == 8'h00)
        else $error("read data not idle");
    ctrl_zero_a: assert property (c_rd |=> !(O_RDATA & ~DTC_C_RMASK))
        else $error("unused control bit set");
    intc_zero_a: assert property (I_RD && I_ADDR == DTC_A_INTC
        |=> !(O_RDATA & ~DTC_I_RMASK)) else $error("unused intc bit set");
    unmap_zero_a: assert property (I_RD && (I_ADDR < DTC_A_INTC
        || I_ADDR > DTC_A_T1C) |=> O_RDATA == 8'h00) else $error("unmapped");
    low_buf_a: assert property (I_WR && I_ADDR == DTC_A_T0L
        ##1 !I_WR ##1 I_RD && I_ADDR == DTC_A_T0L
        |=> O_RDATA == $past(I_WDATA, 3))
        else $error("low buffer lost");
    ctrl_rb_a: assert property (I_WR && I_ADDR == DTC_A_T1C &&
        I_WDATA[7:6] != 2'h3 ##1 !I_WR ##1 I_RD && I_ADDR == DTC_A_T1C
        |=> O_RDATA == ($past(I_WDATA, 3) & DTC_C_RMASK))
        else $error("control readback wrong");
    irq_mask_a: assert property (i_wr && !I_WDATA[3:2] |=> !O_IRQ)
        else $error("masked interrupt raised");
    irq_hold_a: assert property (O_IRQ && !i_wr |=> O_IRQ)
        else $error("interrupt dropped");
    cover property (O_WAKEUP);
    cover property (O_IRQ ##1 !O_IRQ);
    cover property (I_RD && I_ADDR == DTC_A_T0L);
endmodule : dtc_top_sva
bind dtc_top dtc_top_sva u_dtc_top_sva (.I_CORE_CLK, .I_RESETN, .I_ADDR,
    .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_IRQ, .O_WAKEUP);
`default_nettype wire

//--- sim/tb_top.sv
/* bench for dtc_top: register tasks and pin pulses.
   assumes 100 MHz clock, nothing else attached. */
`timescale 1ns/1ps
`default_nettype none
module tb_top import dtc_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [1:0] go = 2'h0;
    logic [1:0] pin;
    logic [7:0] rdata;
    logic irq;
    logic wake;
    logic saw_wake = 1'b0;
    int failures = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    always @(posedge clk) saw_wake <= saw_wake | wake;
    dtc_top u_dtc_top (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(bus_wr), .I_RD(bus_rd), .O_RDATA(rdata),
        .I_TIMER0_INPUT_PIN(pin[0]), .I_TIMER1_INPUT_PIN(pin[1]),
        .O_IRQ(irq), .O_WAKEUP(wake));
    for (genvar g = 0; g < 2; g++) begin : g_pin
        dtc_pin_model u_dtc_pin_model (.i_clk(clk), .i_go(go[g]),
            .i_len(8'h28), .o_pin(pin[g]));
    end
    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        @(posedge clk);
    endtask : reg_wr
    task automatic reg_rd(input logic [5:0] a, input logic [7:0] e);
        addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        chk("read data", e, rdata);
        @(posedge clk);
    endtask : reg_rd
    task automatic pls(input int n, input int w);
        go[n] <= 1'b1;
        @(posedge clk);
        go[n] <= 1'b0;
        repeat (w) @(posedge clk);
    endtask : pls
    initial begin
        int i;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(DTC_A_T0C, 8'h08);
        reg_rd(DTC_A_INTC, 8'h00);
        reg_wr(6'h20, 8'h5a);
        reg_rd(6'h20, 8'h00);
        reg_wr(DTC_A_T1C, 8'hbf);
        reg_rd(DTC_A_T1C, 8'h98);
        reg_wr(DTC_A_T1C, 8'h00);
        reg_wr(DTC_A_T0L, 8'h34);
        reg_rd(DTC_A_T0L, 8'h34);
        reg_rd(DTC_A_T0H, 8'h00);
        reg_wr(DTC_A_T0L, 8'h00);
        reg_wr(DTC_A_T0H, 8'hff);
        reg_rd(DTC_A_T0H, 8'hff);
        reg_wr(DTC_A_INTC, 8'h04);
        reg_wr(DTC_A_T0C, 8'h90);
        reg_wr(DTC_A_T0H, 8'h80);
        reg_rd(DTC_A_T0H, 8'hff);
        for (i = 0; i < 1100 && irq !== 1'b1; i++) @(posedge clk);
        chk("tick rate", 8'h01, {7'h00, i > 1000 && i < 1100});
        if (i >= 1100) test_done();
        reg_rd(DTC_A_T0H, 8'h80);
        reg_rd(DTC_A_INTC, 8'h24);
        chk("wake", 8'h01, {7'h00, saw_wake});
        reg_wr(DTC_A_INTC, 8'h00);
        reg_rd(DTC_A_INTC, 8'h00);
        reg_wr(DTC_A_T0C, 8'h00);
        for (int e = 0; e < 2; e++) begin
            reg_wr(DTC_A_T1L, 8'hff);
            reg_wr(DTC_A_T1H, 8'h00);
            reg_wr(DTC_A_T1C, {4'h5, e[0], 3'h0});
            pls(1, 10);
            reg_rd(DTC_A_T1H, e ? 8'h00 : 8'h01);
            repeat (40) @(posedge clk);
            reg_rd(DTC_A_T1H, 8'h01);
            reg_rd(DTC_A_T1C, {4'h5, e[0], 3'h0});
            reg_wr(DTC_A_T1C, 8'h00);
        end
        reg_wr(DTC_A_T1L, 8'hff);
        reg_wr(DTC_A_T1H, 8'hff);
        reg_wr(DTC_A_T1C, 8'h50);
        pls(1, 10);
        reg_rd(DTC_A_INTC, 8'h40);
        chk("irq masked", 8'h00, {7'h00, irq});
        reg_rd(DTC_A_T1H, 8'hff);
        reg_wr(DTC_A_T1C, 8'h00);
        reg_wr(DTC_A_INTC, 8'h00);
        reg_wr(DTC_A_T0L, 8'hf8);
        reg_wr(DTC_A_T0H, 8'h00);
        pls(0, 4);
        reg_wr(DTC_A_T0C, 8'hd8);
        repeat (50) @(posedge clk);
        reg_rd(DTC_A_T0C, 8'hd8);
        reg_rd(DTC_A_T0H, 8'h00);
        pls(0, 50);
        reg_rd(DTC_A_T0C, 8'hc8);
        reg_rd(DTC_A_T0H, 8'h01);
        pls(0, 50);
        reg_rd(DTC_A_T0H, 8'h01);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
